// [demod_consts.svh]
// Offsets, field positions, reset values and counts of the demodulator setup bank
`ifndef DEMOD_CONSTS_SVH
`define DEMOD_CONSTS_SVH

`define WORD_BITS            32
`define ADDR_LSB             0
`define ADDR_MSB             4
`define ADDR_SETUP_ONE       5'h09
`define ADDR_CAL_SETUP       5'h0a

`define SETUP_ONE_RESET      32'h0100fc89
`define CAL_SETUP_RESET      32'h71e0200a

`define BIT_MIXER_OFF        5
`define BIT_UNUSED_A         6
`define BIT_TEST_BUFFER_OFF  7
`define BIT_BB_FILTER_OFF    8
`define BIT_UNUSED_B         9
`define BIT_OFFSET_CAL_OFF   10
`define BIT_UNUSED_C         11
`define GAIN_LSB             12
`define GAIN_MSB             16
`define CORNER_LSB           17
`define CORNER_MSB           24
`define BIT_DET_RES_SEL      25
`define BIT_DET_CAP_SEL      26
`define BIT_EXT_GAIN_ON      27
`define BIT_GAIN_DOUBLE      28
`define BIT_OSC_TEST         29
`define BIT_UNUSED_D         30
`define BIT_ATTEN_ON         31
`define BIT_AUTOCAL          5

`define GAIN_CODE_MAX        5'h18
`define RB_COUNT_W           6
`define RB_LAST_COUNT        6'h20

`endif

// [demod_pkg.sv]
// Types shared by the demodulator setup bank
package demod_pkg;

  typedef enum logic [1:0] {
    DET_BW_10MHZ,
    DET_BW_10KHZ,
    DET_BW_1KHZ
  } det_bw_t;

  typedef enum logic [1:0] {
    RB_IDLE,
    RB_WAIT,
    RB_SHIFT
  } rb_state_t;

  typedef struct packed {
    logic       output_atten_on;
    logic       osc_test_on;
    logic       gain_step_double;
    logic       ext_gain_ctrl_on;
    logic       detector_capacitor_sel;
    logic       detector_resistor_sel;
    logic [7:0] lowpass_corner_code;
    logic [4:0] baseband_gain_code;
    logic       offset_cal_off;
    logic       bb_filter_off;
    logic       test_buffer_off;
    logic       mixer_off;
  } setup_fields_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
    logic osc;
    logic cal_done;
  } pin_group_t;

endpackage

// [pin_sync.sv]
// Two-stage synchroniser with rising-edge detect for a group of pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,    // System clock
  input  wire logic             rst_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] pin_in,  // Raw pins
  output logic      [WIDTH-1:0] level,   // Synchronised level
  output logic      [WIDTH-1:0] rise     // One-cycle rising-edge pulse
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= pin_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
        end
      end
      // Edge is taken between stage2 and its delayed copy, never stage1
      assign rise[i] = stage2[i] & ~stage3[i];
    end
  endgenerate

  assign level = stage2;

endmodule // pin_sync

// [demod_setup_bank.sv]
// Setup register bank of the demodulator, loaded and read over the three-wire serial port
`include "demod_consts.svh"

// Operation
// - 32-bit word shifted in LSB first
// - Strobe rise copies word to addressed register
// - Readback: idle clock, then 32 bits out
// - Bit 5 powers mixer down, resets zero
// - Bit 7 test buffer off, resets one
// - Bit 8 filter off, resets zero
// - Bit 10 offset calibration off, resets one
// - Bits 12-16 gain code, reset 15
// - Bits 17-24 corner code, reset 128
// - Bits 25-26 select detector bandwidth
// - Bandwidth applies during autocal, resets maximum
// - Bit 27 enables external fast gain
// - Bit 28 doubles each fast-gain step
// - Bit 29 puts oscillator on readback
// - Bit 31 switches in output attenuator
// - Autocal bit self-clears when calibration done
module demod_setup_bank (
  input  wire logic            mclk,           // System clock, 25 MHz
  input  wire logic            rst_n,          // Async reset, active low
  input  wire logic            ser_clk,        // Serial shift clock pin
  input  wire logic            ser_data,       // Serial data pin
  input  wire logic            ser_strobe,     // Load strobe pin
  input  wire logic            osc_in,         // Internal oscillator output
  input  wire logic            cal_done,       // Calibration finished level
  output logic                 readback,       // Readback pin
  output demod_pkg::setup_fields_t setup,      // Decoded first setup word
  output demod_pkg::det_bw_t   detector_bw,    // Offset detector bandwidth
  output logic                 autocal_on,     // Automatic calibration running
  output logic                 gain_code_ok    // Gain code inside 0..24
);

  demod_pkg::pin_group_t raw_pins;
  demod_pkg::pin_group_t pin_level;
  demod_pkg::pin_group_t pin_rise;

  assign raw_pins.sclk     = ser_clk;
  assign raw_pins.sdata    = ser_data;
  assign raw_pins.strobe   = ser_strobe;
  assign raw_pins.osc      = osc_in;
  assign raw_pins.cal_done = cal_done;

  pin_sync #(
    .WIDTH ($bits(demod_pkg::pin_group_t))
  ) u_pin_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .pin_in (raw_pins),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  // ---------------- Serial shift register ----------------

  logic [`WORD_BITS-1:0] shift_word;
  logic [`WORD_BITS-1:0] next_shift_word;

  // New bits enter at the top so the first bit sent ends in bit 0
  always_comb
  begin
    next_shift_word = shift_word;
    if (pin_rise.sclk)
    begin
      next_shift_word = {pin_level.sdata, shift_word[`WORD_BITS-1:1]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_word <= '0;
    end
    else
    begin
      shift_word <= next_shift_word;
    end
  end

  // ---------------- Setup registers ----------------

  logic [`WORD_BITS-1:0] setup_word_one;
  logic [`WORD_BITS-1:0] next_setup_word_one;
  logic [`WORD_BITS-1:0] cal_setup_word;
  logic [`WORD_BITS-1:0] next_cal_setup_word;
  logic [`ADDR_MSB:0]    strobe_addr;
  logic                  hit_one;
  logic                  hit_cal;

  assign strobe_addr = shift_word[`ADDR_MSB:`ADDR_LSB];

  always_comb
  begin
    hit_one = 1'b0;
    hit_cal = 1'b0;
    if (!pin_rise.strobe)
    begin
      hit_one = 1'b0;
    end
    else if (strobe_addr == `ADDR_SETUP_ONE)
    begin
      hit_one = 1'b1;
    end
    else if (strobe_addr == `ADDR_CAL_SETUP)
    begin
      hit_cal = 1'b1;
    end
  end

  always_comb
  begin
    next_setup_word_one = setup_word_one;
    next_cal_setup_word = cal_setup_word;
    if (hit_one)
    begin
      next_setup_word_one = shift_word;
    end
    if (hit_cal)
    begin
      next_cal_setup_word = shift_word;
    end
    // A fresh write of one wins over a finish seen in the same cycle
    if (pin_level.cal_done && !(hit_cal && shift_word[`BIT_AUTOCAL]))
    begin
      next_cal_setup_word[`BIT_AUTOCAL] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_word_one <= `SETUP_ONE_RESET;
      cal_setup_word <= `CAL_SETUP_RESET;
    end
    else
    begin
      setup_word_one <= next_setup_word_one;
      cal_setup_word <= next_cal_setup_word;
    end
  end

  // ---------------- Field outputs ----------------

  // Unused bits 6, 9, 11 and 30 are stored for readback but drive nothing
  assign setup.mixer_off              = setup_word_one[`BIT_MIXER_OFF];
  assign setup.test_buffer_off        = setup_word_one[`BIT_TEST_BUFFER_OFF];
  assign setup.bb_filter_off          = setup_word_one[`BIT_BB_FILTER_OFF];
  assign setup.offset_cal_off         = setup_word_one[`BIT_OFFSET_CAL_OFF];
  assign setup.baseband_gain_code     = setup_word_one[`GAIN_MSB:`GAIN_LSB];
  assign setup.lowpass_corner_code    = setup_word_one[`CORNER_MSB:`CORNER_LSB];
  assign setup.detector_resistor_sel  = setup_word_one[`BIT_DET_RES_SEL];
  assign setup.detector_capacitor_sel = setup_word_one[`BIT_DET_CAP_SEL];
  assign setup.ext_gain_ctrl_on       = setup_word_one[`BIT_EXT_GAIN_ON];
  assign setup.gain_step_double       = setup_word_one[`BIT_GAIN_DOUBLE];
  assign setup.osc_test_on            = setup_word_one[`BIT_OSC_TEST];
  assign setup.output_atten_on        = setup_word_one[`BIT_ATTEN_ON];

  assign autocal_on = cal_setup_word[`BIT_AUTOCAL];

  // ---------------- Decoded status flops ----------------

  demod_pkg::det_bw_t next_detector_bw;
  logic               next_gain_code_ok;

  always_comb
  begin
    // Resistor select low bypasses the whole RC, capacitor select is then ignored
    if (!next_setup_word_one[`BIT_DET_RES_SEL])
    begin
      next_detector_bw = demod_pkg::DET_BW_10MHZ;
    end
    else if (!next_setup_word_one[`BIT_DET_CAP_SEL])
    begin
      next_detector_bw = demod_pkg::DET_BW_10KHZ;
    end
    else
    begin
      next_detector_bw = demod_pkg::DET_BW_1KHZ;
    end
    next_gain_code_ok = (next_setup_word_one[`GAIN_MSB:`GAIN_LSB] <= `GAIN_CODE_MAX);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      detector_bw  <= demod_pkg::DET_BW_10MHZ;
      gain_code_ok <= 1'b1;
    end
    else
    begin
      detector_bw  <= next_detector_bw;
      gain_code_ok <= next_gain_code_ok;
    end
  end

  // ---------------- Readback ----------------

  demod_pkg::rb_state_t   rb_state;
  demod_pkg::rb_state_t   next_rb_state;
  logic [`RB_COUNT_W-1:0] rb_count;
  logic [`RB_COUNT_W-1:0] next_rb_count;
  logic [`WORD_BITS-1:0]  rb_word;
  logic [`WORD_BITS-1:0]  next_rb_word;
  logic                   rb_bit;
  logic                   next_rb_bit;
  logic                   next_readback;

  // Every strobe arms a readback of the word it addressed; an unknown
  // address reads as zeros. Writes echo the written word on the pin unless bit 29 puts the oscillator there.
  always_comb
  begin
    next_rb_state = rb_state;
    next_rb_count = rb_count;
    next_rb_word  = rb_word;
    next_rb_bit   = rb_bit;
    case (rb_state)
      demod_pkg::RB_IDLE:
      begin
        next_rb_bit = 1'b0;
      end
      demod_pkg::RB_WAIT:
      begin
        if (pin_rise.sclk)
        begin
          next_rb_state = demod_pkg::RB_SHIFT;
          next_rb_count = '0;
        end
      end
      demod_pkg::RB_SHIFT:
      begin
        if (pin_rise.sclk)
        begin
          if (rb_count == `RB_LAST_COUNT)
          begin
            next_rb_state = demod_pkg::RB_IDLE;
            next_rb_bit   = 1'b0;
          end
          else
          begin
            next_rb_bit   = rb_word[0];
            next_rb_word  = {1'b0, rb_word[`WORD_BITS-1:1]};
            next_rb_count = rb_count + 1'b1;
            if (rb_count == `RB_LAST_COUNT - 1'b1)
            begin
              next_rb_state = demod_pkg::RB_SHIFT;
            end
          end
        end
      end
      default:
      begin
        next_rb_state = demod_pkg::RB_IDLE;
      end
    endcase
    // A strobe restarts readback whatever state it meets
    if (pin_rise.strobe)
    begin
      next_rb_state = demod_pkg::RB_WAIT;
      next_rb_count = '0;
      if (hit_one)
      begin
        next_rb_word = next_setup_word_one;
      end
      else if (hit_cal)
      begin
        next_rb_word = next_cal_setup_word;
      end
      else
      begin
        next_rb_word = '0;
      end
    end
    if (setup_word_one[`BIT_OSC_TEST])
    begin
      next_readback = pin_level.osc;
    end
    else
    begin
      next_readback = next_rb_bit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rb_state <= demod_pkg::RB_IDLE;
      rb_count <= '0;
      rb_word  <= '0;
      rb_bit   <= 1'b0;
      readback <= 1'b0;
    end
    else
    begin
      rb_state <= next_rb_state;
      rb_count <= next_rb_count;
      rb_word  <= next_rb_word;
      rb_bit   <= next_rb_bit;
      readback <= next_readback;
    end
  end

endmodule // demod_setup_bank

// [demod_setup_bank_sva.sv]
// Port-level assertions for the demodulator setup bank
`include "demod_consts.svh"
module demod_setup_bank_sva (
  input wire logic                     mclk,         // System clock
  input wire logic                     rst_n,        // Async reset, active low
  input wire logic                     ser_clk,      // Serial shift clock pin
  input wire logic                     ser_data,     // Serial data pin
  input wire logic                     ser_strobe,   // Load strobe pin
  input wire logic                     osc_in,       // Oscillator input
  input wire logic                     cal_done,     // Calibration finished
  input wire logic                     readback,     // Readback pin
  input wire demod_pkg::setup_fields_t setup,        // Decoded word one
  input wire demod_pkg::det_bw_t       detector_bw,  // Detector bandwidth
  input wire logic                     autocal_on,   // Calibration running
  input wire logic                     gain_code_ok  // Gain code in range
);
  localparam logic [31:0] RST = `SETUP_ONE_RESET;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Windows are longer than the pin synchroniser delay so latency slop cannot fire them
  sequence strobe_quiet;
    (!ser_strobe) [*6];
  endsequence
  sequence cal_held;
    (cal_done && !ser_strobe) [*8];
  endsequence
  sequence osc_shown;
    (setup.osc_test_on && $stable(osc_in)) [*5];
  endsequence
  sequence link_idle;
    (!setup.osc_test_on && !ser_clk && !ser_strobe) [*8];
  endsequence
  a_reset_vals: assert property ($rose(rst_n) |->
    setup == {RST[31], RST[29:12], RST[10], RST[8:7], RST[5]} && !autocal_on && !readback)
    else $error("setup outputs differ from reset values");
  a_bw_decode: assert property ($stable(setup) |-> detector_bw ==
    (!setup.detector_resistor_sel ? demod_pkg::DET_BW_10MHZ :
     setup.detector_capacitor_sel ? demod_pkg::DET_BW_1KHZ : demod_pkg::DET_BW_10KHZ))
    else $error("detector bandwidth does not match select bits");
  a_gain_range: assert property ($stable(setup) |->
    gain_code_ok == (setup.baseband_gain_code <= 5'h18))
    else $error("gain range flag wrong");
  a_setup_hold: assert property (strobe_quiet |=> $stable(setup))
    else $error("setup changed without a strobe");
  a_autocal_clear: assert property (cal_held |=> !autocal_on)
    else $error("calibration bit not cleared");
  a_autocal_fall: assert property ($fell(autocal_on) |-> $past(cal_done, 2) ||
    $past(cal_done, 3) || $past(cal_done, 4) || $past(ser_strobe, 3))
    else $error("calibration bit fell without cause");
  a_osc_route: assert property (osc_shown |-> readback == osc_in)
    else $error("readback does not show oscillator");
  a_rb_quiet: assert property (link_idle |=> $stable(readback))
    else $error("readback moved without a shift clock");
endmodule // demod_setup_bank_sva

bind demod_setup_bank demod_setup_bank_sva chk (.mclk(mclk), .rst_n(rst_n), .ser_clk(ser_clk),
  .ser_data(ser_data), .ser_strobe(ser_strobe), .osc_in(osc_in), .cal_done(cal_done),
  .readback(readback), .setup(setup), .detector_bw(detector_bw), .autocal_on(autocal_on),
  .gain_code_ok(gain_code_ok));

// [ser_ctrl_model.sv]
// Serial controller model: shifts a word in, strobes it, then clocks the readback out
module ser_ctrl_model (
  output logic      ser_clk,    // Shift clock, still low between frames
  output logic      ser_data,   // Data to the device
  output logic      ser_strobe, // Load strobe
  input  wire logic readback    // Readback from the device
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 160;
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_strobe = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, output logic [31:0] rb);
    for (int i = 0; i < 32; i++)
    begin
      ser_data = w[i];
      #HALF ser_clk = 1'b1;
      #HALF ser_clk = 1'b0;
    end
    #HALF ser_strobe = 1'b1;
    #(2 * HALF) ser_strobe = 1'b0;
    #HALF;
    for (int i = 0; i < 34; i++)
    begin
      // Data line keeps toggling so a device that samples it here is caught
      ser_data = ~ser_data;
      #HALF ser_clk = 1'b1;
      #HALF ser_clk = 1'b0;
      if (i >= 1 && i <= 32)
        rb[i - 1] = readback;
    end
  endtask
endmodule // ser_ctrl_model

// [demod_setup_bank_bench.sv]
// Self-checking bench for the demodulator setup bank
`include "demod_consts.svh"
module demod_setup_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     mclk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     osc_in = 1'b0;
  logic                     cal_done = 1'b0;
  wire logic                ser_clk, ser_data, ser_strobe, readback;
  demod_pkg::setup_fields_t setup;
  demod_pkg::det_bw_t       detector_bw;
  logic                     autocal_on, gain_code_ok;
  logic [31:0]              rb;
  int                       n_errors = 0;
  int                       cmp_count = 0;
  always #20 mclk = ~mclk;
  demod_setup_bank uut (.mclk(mclk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_strobe(ser_strobe), .osc_in(osc_in), .cal_done(cal_done), .readback(readback),
    .setup(setup), .detector_bw(detector_bw), .autocal_on(autocal_on), .gain_code_ok(gain_code_ok));
  ser_ctrl_model ctl (.ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe), .readback(readback));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] fields(input logic [31:0] w);
    return {9'h000, w[31], w[29:12], w[10], w[8:7], w[5]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset();
    check("setup", 32'(setup), fields(`SETUP_ONE_RESET));
    check("detector_bw", 32'(detector_bw), 32'(demod_pkg::DET_BW_10MHZ));
    check("autocal_on", 32'(autocal_on), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_fields();
    logic [31:0] w;
    for (int i = 0; i < 4; i++)
    begin
      // Walks all bandwidth selects and gain codes either side of the top code
      w = 32'h9 | (32'(i) << 25) | (32'(23 + i) << 12) | (i[0] ? 32'h01fe_0000 : 32'h0)
        | (i[1] ? 32'h9800_0da0 : 32'h4000_0840);
      ctl.xfer(w, rb);
      cyc(1);
      check("readback", rb, w);
      check("setup", 32'(setup), fields(w));
      check("detector_bw", 32'(detector_bw), 32'(!w[25] ? demod_pkg::DET_BW_10MHZ :
        w[26] ? demod_pkg::DET_BW_1KHZ : demod_pkg::DET_BW_10KHZ));
      check("gain_code_ok", 32'(gain_code_ok), 32'(w[16:12] <= 5'h18));
    end
    $display("test fields done");
  endtask
  task automatic t_unmapped();
    logic [31:0] prev;
    prev = 32'(setup);
    ctl.xfer(32'hffff_fff3, rb);
    cyc(1);
    check("readback", rb, 32'h0);
    check("setup", 32'(setup), prev);
    $display("test unmapped done");
  endtask
  task automatic t_autocal();
    int k;
    ctl.xfer(32'h0000_002a, rb);
    cyc(1);
    check("autocal_on", 32'(autocal_on), 32'h1);
    cal_done = 1'b1;
    for (k = 0; k < 20 && autocal_on !== 1'b0; k++)
      cyc(1);
    check("autocal_on", 32'(autocal_on), 32'h0);
    if (k == 20)
      print_verdict();
    cyc(10);
    cal_done = 1'b0;
    $display("test autocal done");
  endtask
  task automatic t_osc();
    ctl.xfer(32'h2000_0009, rb);
    check("readback", rb, 32'h0);
    osc_in = 1'b1;
    cyc(6);
    check("readback", 32'(readback), 32'h1);
    osc_in = 1'b0;
    cyc(6);
    check("readback", 32'(readback), 32'h0);
    ctl.xfer(32'h0000_0009, rb);
    check("readback", rb, 32'h0000_0009);
    $display("test osc done");
  endtask
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    t_reset();
    t_fields();
    t_unmapped();
    t_autocal();
    t_osc();
    print_verdict();
  end
endmodule // demod_setup_bank_bench
